// [design/fcodc_pkg.sv]
// Package for the four-channel output and diagnostic control block.
// Assumes a single 50 MHz clock; no bus, all settings arrive as plain ports.
package fcodc_pkg;
  // Number of channels, each its own channel group.
  localparam int unsigned NCH = 4;
  // Default values applied while no parameters have been received.
  localparam logic DEF_IRQ_EN = 1'h0;
  localparam logic DEF_RETAIN = 1'h0;
  localparam logic DEF_SUBST_EN = 1'h1;
  localparam logic DEF_SUBST_VAL = 1'h0;
  localparam logic [3:0] DEF_DIAG_EN = 4'h0;
  // Module-wide diagnostic bit positions.
  localparam int unsigned MD_NOCFG = 0;
  localparam int unsigned MD_AUX = 1;
  localparam int unsigned MD_FUSE = 2;
  localparam int unsigned MD_WDOG = 3;
  localparam int unsigned MD_EPROM = 4;
  localparam int unsigned MD_RAM = 5;
  localparam int unsigned MD_CPU = 6;
  localparam int unsigned MD_PARAM = 7;
  localparam int unsigned MD_W = 8;
  // Scope tag values attached to the diagnostic record.
  localparam logic SCOPE_GROUP = 1'h0;
  localparam logic SCOPE_MODULE = 1'h1;

  // Parameter block as loaded by the host.
  typedef struct packed {
    logic irq_en;
    logic retain;
    logic subst_en;
    logic subst_val;
    logic [NCH-1:0] sc_en;
    logic [NCH-1:0] wb_en;
    logic [NCH-1:0] nl_en;
  } fcodc_param_s;

  // Per-channel raw fault inputs from the analog front end.
  typedef struct packed {
    logic [NCH-1:0] short_gnd;
    logic [NCH-1:0] wb_low_cur;
    logic [NCH-1:0] no_load_v;
  } fcodc_chfault_s;

  // Diagnostic record presented to the host.
  typedef struct packed {
    logic scope_module;
    logic [MD_W-1:0] module_diag;
    logic [NCH-1:0] sc;
    logic [NCH-1:0] wb;
    logic [NCH-1:0] nl;
  } fcodc_diag_s;

  // Host operating state, Gray coded along power-off, stop, run.
  typedef enum logic [1:0] {
    HOST_OFF = 2'h0,
    HOST_STOP = 2'h1,
    HOST_RUN = 2'h3
  } fcodc_host_e;
endpackage : fcodc_pkg

// [design/fcodc_out_sel.sv]
// Output value selector for one channel.
// Assumes host state and load supply already synchronised.
`timescale 1ns/1ps
`default_nettype none
module fcodc_out_sel (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire fcodc_pkg::fcodc_host_e i_host,
  input wire logic i_load_ok,
  input wire logic i_host_val,
  input wire logic i_retain,
  input wire logic i_subst_en,
  input wire logic i_subst_val,
  output logic o_out
);
  import fcodc_pkg::*;
  // Last value driven while the host was in run with load present.
  logic last_q;
  logic last_d;
  logic out_q;
  logic out_d;

  // Chooses host value, substitute, last value or zero.
  always_comb begin
    last_d = last_q;
    out_d = 1'h0;
    if (!i_load_ok || i_host == HOST_OFF) begin
      out_d = 1'h0; // RQ17
    end else if (i_host == HOST_RUN) begin
      out_d = i_host_val; // RQ17
      last_d = i_host_val;
    end else if (i_retain) begin
      out_d = last_q; // RQ3
    end else if (i_subst_en) begin
      out_d = i_subst_val; // RQ18
    end else begin
      out_d = 1'h0;
    end
  end

  // Registers the selection.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      last_q <= 1'h0;
      out_q <= 1'h0;
    end else if (i_ce) begin
      last_q <= last_d;
      out_q <= out_d;
    end
  end

  assign o_out = out_q;
endmodule : fcodc_out_sel
`default_nettype wire

// [design/fcodc_top.sv]
// Control and diagnostic logic of a four-channel digital output module.
// Assumes front-end fault levels and load supply come from pins, so they are synchronised.
// Overview of operation
// RQ1: Four channels, channel n in group n.
// RQ2: Built-in defaults until host loads parameters.
// RQ3: Retain-last-value setting, default no.
// RQ4: Substitute enable default yes, value zero.
// RQ5: Interrupt disabled until host enables it.
// RQ6: Group faults reported only when enabled.
// RQ7: Module-wide faults always reported.
// RQ8: Diagnostics tagged group or module scope.
// RQ9: Interrupt only when interrupt enable set.
// RQ10: Interrupt on incoming and outgoing errors.
// RQ11: Disabled diagnostics never raise interrupts.
// RQ12: Known faults always light indicators.
// RQ13: Wire break lights indicators only enabled.
// RQ14: Wire break from low-current comparator.
// RQ15: Channel faults evaluated only with output high.
// RQ16: Invalid parameters flagged until valid reload.
// RQ17: Run drives host value; no supply gives zero.
// RQ18: Stop gives substitute or last value.
// RQ19: Load supply failure lights group indicator.
// RQ20: Host changes static parameters only in stop; the block accepts parameter loads in any host state.
// RQ21: Interrupt held until host reads diagnostics.
`timescale 1ns/1ps
`default_nettype none
module fcodc_top (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire fcodc_pkg::fcodc_host_e i_host,
  input wire logic [fcodc_pkg::NCH-1:0] i_host_val,
  input wire logic i_param_load,
  input wire logic i_param_valid,
  input wire fcodc_pkg::fcodc_param_s i_param,
  input wire logic i_diag_read,
  input wire logic i_load_ok,
  input wire fcodc_pkg::fcodc_chfault_s i_chfault,
  input wire logic [6:0] i_mod_fault,
  output logic [fcodc_pkg::NCH-1:0] o_out,
  output logic o_group_fault_indicator,
  output logic [fcodc_pkg::NCH-1:0] o_ch_fault_ind,
  output logic o_diag_irq,
  output fcodc_pkg::fcodc_diag_s o_diag
);
  import fcodc_pkg::*;

  // Two-stage synchronisers for pin levels; stage one is read only by stage two.
  logic [3*NCH+7:0] sync1_q;
  logic [3*NCH+7:0] sync2_q;
  logic load_ok_s;
  fcodc_chfault_s chf_s;
  logic [6:0] modf_s;

  // Samples asynchronous pin levels.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (i_ce) begin
      sync1_q <= {i_load_ok, i_mod_fault, i_chfault};
      sync2_q <= sync1_q;
    end
  end

  assign load_ok_s = sync2_q[3*NCH+7];
  assign modf_s = sync2_q[3*NCH+6:3*NCH];
  assign chf_s = sync2_q[3*NCH-1:0];

  // Active parameter set, with the configured flag and parameter error.
  fcodc_param_s par_q;
  fcodc_param_s par_d;
  logic cfg_q;
  logic cfg_d;
  logic perr_q;
  logic perr_d;

  // Accepts a parameter block; invalid ones keep the old set and flag an error.
  always_comb begin
    par_d = par_q;
    cfg_d = cfg_q;
    perr_d = perr_q;
    if (i_param_load) begin
      if (i_param_valid) begin
        par_d = i_param;
        cfg_d = 1'h1;
        perr_d = 1'h0; // RQ16
      end else begin
        perr_d = 1'h1; // RQ16
      end
    end
  end

  // Registers the parameter state; reset applies the built-in defaults.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      par_q <= '{irq_en: DEF_IRQ_EN, retain: DEF_RETAIN, subst_en: DEF_SUBST_EN, // RQ2
                 subst_val: DEF_SUBST_VAL, sc_en: DEF_DIAG_EN, wb_en: DEF_DIAG_EN,
                 nl_en: DEF_DIAG_EN}; // RQ4 RQ5
      cfg_q <= 1'h0;
      perr_q <= 1'h0;
    end else if (i_ce) begin
      par_q <= par_d;
      cfg_q <= cfg_d;
      perr_q <= perr_d;
    end
  end

  // One output selector per channel, each channel being its own group.
  logic [NCH-1:0] out_w;
  for (genvar g = 0; g < NCH; g++) begin : g_ch // RQ1
    fcodc_out_sel u_sel (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_host(i_host),
      .i_load_ok(load_ok_s),
      .i_host_val(i_host_val[g]),
      .i_retain(par_q.retain),
      .i_subst_en(par_q.subst_en),
      .i_subst_val(par_q.subst_val),
      .o_out(out_w[g])
    );
  end
  // Channel outputs come straight from the selector registers.
  assign o_out = out_w;

  // Gates a raw per-channel fault with output state and enable.
  function automatic logic [NCH-1:0] gate_fault(input logic [NCH-1:0] raw, input logic [NCH-1:0] en,
                                                input logic [NCH-1:0] drv);
    gate_fault = raw & en & drv;
  endfunction : gate_fault

  // Qualified channel faults and module-wide fault word.
  logic [NCH-1:0] sc_w;
  logic [NCH-1:0] wb_w;
  logic [NCH-1:0] nl_w;
  logic [MD_W-1:0] mod_w;
  logic [NCH-1:0] sc_raw;
  logic [NCH-1:0] wb_raw;
  logic [NCH-1:0] nl_raw;
  assign sc_raw = gate_fault(chf_s.short_gnd, '1, out_w); // RQ15
  assign wb_raw = gate_fault(chf_s.wb_low_cur, '1, out_w); // RQ14 RQ15
  assign nl_raw = gate_fault(chf_s.no_load_v, '1, out_w); // RQ15
  assign sc_w = sc_raw & par_q.sc_en; // RQ6
  assign wb_w = wb_raw & par_q.wb_en; // RQ6
  assign nl_w = nl_raw & par_q.nl_en;
  // Module-wide faults are never masked.
  // A missing load supply is also recorded as missing auxiliary voltage.
  assign mod_w = {perr_q, modf_s[6:2], modf_s[1] | ~load_ok_s, modf_s[0] | ~cfg_q | perr_q}; // RQ7 RQ19

  // Diagnostic record, indicators and interrupt.
  fcodc_diag_s diag_q;
  fcodc_diag_s diag_d;
  logic gfi_q;
  logic gfi_d;
  logic [NCH-1:0] cfi_q;
  logic [NCH-1:0] cfi_d;
  logic irq_q;
  logic irq_d;
  logic evt_w;

  // Any change of a reported fault is an incoming or outgoing event.
  assign evt_w = ({mod_w, sc_w, wb_w, nl_w} != {diag_q.module_diag, diag_q.sc, diag_q.wb, diag_q.nl}); // RQ10 RQ11

  // Builds the next record, indicator states and pending request.
  always_comb begin
    diag_d.module_diag = mod_w; // RQ7
    diag_d.sc = sc_w;
    diag_d.wb = wb_w;
    diag_d.nl = nl_w;
    diag_d.scope_module = (mod_w != '0) ? SCOPE_MODULE : SCOPE_GROUP; // RQ8
    // Short and no-load always light channel lamps; wire break only when enabled.
    cfi_d = sc_raw | nl_raw | wb_w; // RQ12 RQ13
    gfi_d = (cfi_d != '0) || (mod_w != '0) || !load_ok_s; // RQ12 RQ19
    irq_d = irq_q;
    if (i_diag_read) begin
      irq_d = 1'h0; // RQ21
    end
    if (evt_w && par_q.irq_en) begin
      irq_d = 1'h1; // RQ9 RQ10
    end
  end

  // Registers record, indicators and request.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      diag_q <= '0;
      gfi_q <= 1'h0;
      cfi_q <= '0;
      irq_q <= 1'h0;
    end else if (i_ce) begin
      diag_q <= diag_d;
      gfi_q <= gfi_d;
      cfi_q <= cfi_d;
      irq_q <= irq_d;
    end
  end

  // Top-level outputs are taken straight from their registers.
  assign o_diag = diag_q;
  assign o_group_fault_indicator = gfi_q;
  assign o_ch_fault_ind = cfi_q;
  assign o_diag_irq = irq_q;

  // Helper: a request must follow a qualified event when enabled.
  sequence s_evt;
    i_ce && evt_w && par_q.irq_en;
  endsequence

  a_irq_on_event: assert property (@(posedge i_clk) disable iff (i_srst) s_evt |=> o_diag_irq) // RQ10
    else $error("interrupt not raised on diagnostic change");
  a_irq_enable: assert property (@(posedge i_clk) disable iff (i_srst) // RQ9
    (i_ce && !o_diag_irq && !par_q.irq_en) |=> !o_diag_irq)
    else $error("interrupt raised while disabled");
  a_irq_hold: assert property (@(posedge i_clk) disable iff (i_srst) // RQ21
    (i_ce && o_diag_irq && !i_diag_read) |=> o_diag_irq)
    else $error("pending interrupt dropped without read");
  a_irq_clear: assert property (@(posedge i_clk) disable iff (i_srst) // RQ21
    (i_ce && i_diag_read && !(evt_w && par_q.irq_en)) |=> !o_diag_irq)
    else $error("interrupt not cleared by read");
  a_wb_masked: assert property (@(posedge i_clk) disable iff (i_srst) // RQ6
    (i_ce && par_q.wb_en == '0) |=> o_diag.wb == '0)
    else $error("wire break reported while disabled");
  a_sc_gate_out: assert property (@(posedge i_clk) disable iff (i_srst) // RQ15
    (i_ce && out_w == '0) |=> o_diag.sc == '0)
    else $error("short reported with output low");
  a_load_fail_gfi: assert property (@(posedge i_clk) disable iff (i_srst) // RQ19
    (i_ce && !load_ok_s) |=> o_group_fault_indicator)
    else $error("supply failure not shown");
  a_nocfg_report: assert property (@(posedge i_clk) disable iff (i_srst) // RQ7 RQ8
    (i_ce && !cfg_q) |=> o_diag.module_diag[MD_NOCFG] && o_diag.scope_module)
    else $error("not configured fault missing");
  a_out_nosupply: assert property (@(posedge i_clk) disable iff (i_srst) // RQ17
    (i_ce && !load_ok_s) |=> o_out == '0)
    else $error("output driven without supply");
  a_param_err: assert property (@(posedge i_clk) disable iff (i_srst) // RQ16
    (i_ce && i_param_load && !i_param_valid) |=> ##1 o_diag.module_diag[MD_PARAM])
    else $error("invalid parameters not flagged");
  a_irq_default: assert property (@(posedge i_clk) disable iff (i_srst) $past(i_srst) |-> !par_q.irq_en) // RQ5
    else $error("interrupt enabled after defaults");

  // Steps of a parameter load: a taken valid block and a refused invalid one.
  sequence s_load_good;
    i_ce && i_param_load && i_param_valid;
  endsequence

  sequence s_load_bad;
    i_ce && i_param_load && !i_param_valid;
  endsequence

  // A valid block becomes the active set and clears both configuration faults.
  a_param_take: assert property (@(posedge i_clk) disable iff (i_srst) // RQ16
    s_load_good |=> (par_q == $past(i_param)) && cfg_q && !perr_q)
    else $error("valid parameters not taken");

  // A refused block leaves the active set alone and raises the parameter fault.
  a_param_keep: assert property (@(posedge i_clk) disable iff (i_srst) // RQ16
    s_load_bad |=> (par_q == $past(par_q)) && perr_q)
    else $error("invalid parameters not refused");

  // Host run with supply present passes the host value through.
  a_run_value: assert property (@(posedge i_clk) disable iff (i_srst) // RQ17
    (i_ce && load_ok_s && i_host == HOST_RUN) |=> o_out == $past(i_host_val))
    else $error("run output differs from host value");

  // Host power off forces every output low.
  a_off_zero: assert property (@(posedge i_clk) disable iff (i_srst) // RQ17
    (i_ce && i_host == HOST_OFF) |=> o_out == '0)
    else $error("output driven with host off");

  // Host stop with substitution enabled and no retain drives the substitute bit on every channel.
  a_stop_subst: assert property (@(posedge i_clk) disable iff (i_srst) // RQ18
    (i_ce && load_ok_s && i_host == HOST_STOP && !par_q.retain && par_q.subst_en)
    |=> o_out == {NCH{$past(par_q.subst_val)}})
    else $error("substitute value not driven in stop");

  // A module fault lights the group lamp and marks the record module scoped.
  a_mod_gfi: assert property (@(posedge i_clk) disable iff (i_srst) // RQ12 RQ8
    (i_ce && modf_s != '0) |=> o_group_fault_indicator && o_diag.scope_module)
    else $error("module fault not shown");

  // A missing load supply also appears as missing auxiliary voltage.
  a_aux_load: assert property (@(posedge i_clk) disable iff (i_srst) // RQ19
    (i_ce && !load_ok_s) |=> o_diag.module_diag[MD_AUX])
    else $error("supply failure not recorded");

  // With wire break masked and no other raw fault, no channel lamp lights.
  a_wb_lamp: assert property (@(posedge i_clk) disable iff (i_srst) // RQ13
    (i_ce && par_q.wb_en == '0 && chf_s.short_gnd == '0 && chf_s.no_load_v == '0) |=> o_ch_fault_ind == '0)
    else $error("masked wire break lit a lamp");

  // A masked no-load fault never reaches the record, so it cannot raise a request.
  a_nl_masked: assert property (@(posedge i_clk) disable iff (i_srst) // RQ6 RQ11
    (i_ce && par_q.nl_en == '0) |=> o_diag.nl == '0)
    else $error("no-load reported while disabled");

  // A masked short never reaches the record.
  a_sc_masked: assert property (@(posedge i_clk) disable iff (i_srst) // RQ6
    (i_ce && par_q.sc_en == '0) |=> o_diag.sc == '0)
    else $error("short reported while disabled");

  // A short on a driven channel always lights that channel's lamp.
  a_sc_lamp: assert property (@(posedge i_clk) disable iff (i_srst) // RQ12
    (i_ce && sc_raw != '0) |=> (o_ch_fault_ind & $past(sc_raw)) == $past(sc_raw))
    else $error("short not shown on channel lamp");
endmodule : fcodc_top
`default_nettype wire

// [dv/fcodc_host_model.sv]
// Host controller model on the far side of the diagnostic interface.
// Assumes the same clock as the block; it reads diagnostics when allowed.
`timescale 1ns/1ps
`default_nettype none
module fcodc_host_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ack_en,
  input wire logic i_diag_irq,
  output logic o_diag_read
);
  // A pending interrupt is acknowledged by a one-cycle diagnostic read.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_diag_read <= 1'h0;
    end else begin
      o_diag_read <= i_ack_en & i_diag_irq & ~o_diag_read;
    end
  end
endmodule : fcodc_host_model
`default_nettype wire

// [dv/fcodc_test.sv]
// Self-checking testbench for the output and diagnostic control block.
// Assumes the host model acknowledges interrupts while acknowledgement is on.
`timescale 1ns/1ps
`default_nettype none
module fcodc_test;
  import fcodc_pkg::*;
  logic clk = 1'h0;
  logic srst = 1'h1;
  fcodc_host_e host = HOST_STOP;
  logic [3:0] hval = 4'hf;
  logic pload = 1'h0;
  logic pvalid = 1'h0;
  fcodc_param_s par = '0;
  logic rd;
  logic ack = 1'h1;
  logic ce = 1'h1;
  logic lok = 1'h1;
  fcodc_chfault_s chf = '0;
  logic [6:0] mf = 7'h0;
  logic [3:0] out;
  logic gfi;
  logic [3:0] chi;
  logic irq;
  fcodc_diag_s dg;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  fcodc_top u_fcodc_top (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_host(host), .i_host_val(hval),
    .i_param_load(pload), .i_param_valid(pvalid), .i_param(par), .i_diag_read(rd), .i_load_ok(lok),
    .i_chfault(chf), .i_mod_fault(mf), .o_out(out), .o_group_fault_indicator(gfi),
    .o_ch_fault_ind(chi), .o_diag_irq(irq), .o_diag(dg));
  fcodc_host_model u_fcodc_host_model (.i_clk(clk), .i_srst(srst), .i_ack_en(ack), .i_diag_irq(irq),
    .o_diag_read(rd));
  // The clock toggles every half period of 10 ns.
  always #10 clk = ~clk;
  // The cycle ceiling stops a hung run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Lets the pin synchronisers and registers settle.
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask : settle
  // Loads one parameter block with the given validity.
  task automatic load(input fcodc_param_s p, input logic v);
    @(posedge clk);
    #1 par = p;
    pload = 1'h1;
    pvalid = v;
    @(posedge clk);
    #1 pload = 1'h0;
    settle();
  endtask : load
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // Main sequence of scenarios.
  initial begin
    repeat (8) @(posedge clk);
    #1 srst = 1'h0;
    settle();
    chk(dg.module_diag[MD_NOCFG], 1'h1);
    chk(irq, 1'h0);
    chk(out, 4'h0);
    host = HOST_RUN;
    settle();
    chk(out, 4'hf);
    ce = 1'h0;
    hval = 4'h3;
    settle();
    chk(out, 4'hf);
    ce = 1'h1;
    hval = 4'hf;
    host = HOST_STOP;
    load('{irq_en: 1'h1, retain: 1'h0, subst_en: 1'h1, subst_val: 1'h1, sc_en: 4'h0, wb_en: 4'h1,
      nl_en: 4'h0}, 1'h1);
    chk(dg.module_diag[MD_NOCFG], 1'h0);
    chk(out, 4'hf);
    host = HOST_RUN;
    ack = 1'h0;
    chf.short_gnd = 4'h2;
    settle();
    chk(dg.sc, 4'h0);
    chk(irq, 1'h0);
    chk(chi, 4'h2);
    chf.wb_low_cur = 4'h5;
    settle();
    chk(dg.wb, 4'h1);
    chk(chi, 4'h3);
    chk(dg.scope_module, SCOPE_GROUP);
    chk(irq, 1'h1);
    ack = 1'h1;
    settle();
    chk(irq, 1'h0);
    ack = 1'h0;
    hval = 4'he;
    settle();
    chk(dg.wb, 4'h0);
    chk(irq, 1'h1);
    ack = 1'h1;
    chf = '0;
    hval = 4'h5;
    mf = 7'h4;
    settle();
    chk(dg.module_diag[MD_FUSE], 1'h1);
    chk(dg.scope_module, SCOPE_MODULE);
    chk(gfi, 1'h1);
    mf = 7'h0;
    host = HOST_STOP;
    load('{irq_en: 1'h0, retain: 1'h1, subst_en: 1'h1, subst_val: 1'h0, sc_en: 4'hf, wb_en: 4'h0,
      nl_en: 4'h4}, 1'h1);
    chk(out, 4'h5);
    chf.short_gnd = 4'h1;
    chf.no_load_v = 4'h5;
    settle();
    chk(dg.sc, 4'h1);
    chk(irq, 1'h0);
    chk(dg.nl, 4'h4);
    chk(chi, 4'h5);
    chf = '0;
    load('0, 1'h0);
    chk(dg.module_diag[MD_PARAM], 1'h1);
    chk(dg.module_diag[MD_NOCFG], 1'h1);
    chk(out, 4'h5);
    lok = 1'h0;
    settle();
    chk(out, 4'h0);
    chk(gfi, 1'h1);
    chk(dg.module_diag[MD_AUX], 1'h1);
    lok = 1'h1;
    host = HOST_OFF;
    settle();
    chk(out, 4'h0);
    srst = 1'h1;
    repeat (2) @(posedge clk);
    #1 srst = 1'h0;
    settle();
    chk(dg.module_diag[MD_NOCFG], 1'h1);
    chk(dg.module_diag[MD_PARAM], 1'h0);
    chk(irq, 1'h0);
    results();
  end
endmodule : fcodc_test
`default_nettype wire
